// [common/vupm_pkg.sv]
// Purpose: shared constants for the video port management attribute bank
// Assumes: one attribute per index on the management access port
// Notes:   attribute indices follow the order of the attribute list
package vupm_pkg;

    localparam logic [2:0] VUPM_ATTR_PORT_ID    = 3'h1;
    localparam logic [2:0] VUPM_ATTR_ADMIN      = 3'h2;
    localparam logic [2:0] VUPM_ATTR_OPER       = 3'h3;
    localparam logic [2:0] VUPM_ATTR_INHIBIT    = 3'h4;
    localparam logic [2:0] VUPM_ATTR_INTERVAL   = 3'h5;
    localparam logic [2:0] VUPM_ATTR_POWER      = 3'h6;

    localparam logic [7:0] VUPM_ADMIN_RST       = 8'h00;
    localparam logic [7:0] VUPM_POWER_RST       = 8'h00;
    localparam logic [7:0] VUPM_INHIBIT_RST     = 8'h00;
    localparam logic [7:0] VUPM_INTERVAL_RST    = 8'h00;
    localparam logic [7:0] VUPM_VAL_LOCKED      = 8'h01;
    localparam logic [7:0] VUPM_VAL_ON          = 8'h01;
    localparam logic [7:0] VUPM_OPER_ENABLED    = 8'h00;
    localparam logic [7:0] VUPM_OPER_DISABLED   = 8'h01;

    localparam logic [3:0] VUPM_NOTICE_OPER     = 4'h2;
    localparam logic [3:0] VUPM_NOTICE_TIMER    = 4'h3;
    localparam logic [7:0] VUPM_ALARM_LOS       = 8'h00;
    localparam logic [7:0] VUPM_ALARM_LOW       = 8'h01;
    localparam logic [7:0] VUPM_ALARM_HIGH      = 8'h02;

    // one interval unit is one minute: 60 s at 250 MHz
    localparam real         VUPM_CLK_MHZ        = 250.0;
    localparam int          VUPM_UNIT_S         = 60;
    localparam longint      VUPM_UNIT_CYCLES    = longint'(VUPM_UNIT_S) * 250_000_000;

endpackage

// [verification/video_uni_port_mgmt_attrs_tb.sv]
// Purpose: self-checking bench of the video port management attribute bank
// Assumes: interval unit shortened to 10 cycles
// Notes:   alarm and notice pulses are counted by a monitor
`timescale 1ns/10ps
module video_uni_port_mgmt_attrs_tb
    import vupm_pkg::*;
;
    logic        clk_sys = 1'b0, srst = 1'b1, port_fault = 1'b0;
    logic [7:0]  slot_num = 8'h00, port_num = 8'h00, alarm_code, last_alarm = 8'hff, r;
    logic [2:0]  causes = 3'h0, conds = 3'h0, attr_sel, alarm_active;
    logic        get_req, set_req, get_ack, set_ack, attr_error, entity_present, er, ok;
    logic        user_enable, coax_power_on, alarm_pulse, attribute_change_notice;
    logic [7:0]  set_data;
    logic [15:0] get_data, rd;
    logic [3:0]  notice_number, last_notice = 4'hf;
    logic [31:0] seed = 32'h2ad8a073;
    int          fail_count = 0, total_checks = 0, cyc = 0, n_alarm = 0, n_notice = 0;
    int          base, k;

    vupm_attr_bank #(.UNIT_CYCLES(10)) DUT (.clk_sys(clk_sys), .srst(srst),
        .slot_num(slot_num), .port_num(port_num), .factory_port(causes[2]),
        .slot_provisioned(causes[1]), .slot_fitted(causes[0]), .port_fault(port_fault),
        .video_signal_absent(conds[0]), .rf_level_under_range(conds[1]),
        .rf_level_over_range(conds[2]), .get_req(get_req), .set_req(set_req),
        .attr_sel(attr_sel), .set_data(set_data), .get_data(get_data), .get_ack(get_ack),
        .set_ack(set_ack), .attr_error(attr_error), .entity_present(entity_present),
        .user_enable(user_enable), .coax_power_on(coax_power_on),
        .alarm_pulse(alarm_pulse), .alarm_code(alarm_code), .alarm_active(alarm_active),
        .attribute_change_notice(attribute_change_notice), .notice_number(notice_number));

    vupm_mgr_model mgr (.clk_sys(clk_sys), .get_ack(get_ack), .set_ack(set_ack),
        .attr_error(attr_error), .get_data(get_data), .get_req(get_req),
        .set_req(set_req), .attr_sel(attr_sel), .set_data(set_data));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    function automatic logic [15:0] exp_id(input logic [7:0] s, input logic [7:0] p);
        return {s, p};
    endfunction

    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] g, input logic [15:0] x, input string m);
        total_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask

    task automatic chk_bit(input logic g, input logic x, input string m);
        chk_val({15'h0, g}, {15'h0, x}, m);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic acc(input logic wr, input logic [2:0] sel, input logic [7:0] din);
        seed = lfsr(seed);
        mgr.access(wr, sel, din, int'(seed[1:0]), rd, er, ok);
        chk_bit(ok, 1'b1, "no answer");
    endtask

    // monitor: counts pulses and keeps the last code; also cuts a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (alarm_pulse === 1'b1) begin
            n_alarm++;
            last_alarm = alarm_code;
        end
        if (attribute_change_notice === 1'b1) begin
            n_notice++;
            last_notice = notice_number;
        end
        if (cyc == 4000) begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = lfsr(seed);
        slot_num = seed[7:0];
        port_num = seed[15:8] | 8'h01;
        step(4);
        srst = 1'b0;
        acc(1'b0, VUPM_ATTR_ADMIN, 8'h00);
        chk_bit(er, 1'b1, "absent get");
        for (k = 0; k < 3; k++) begin
            causes = 3'h1 << k;
            step(2);
            chk_bit(entity_present, 1'b1, "present");
            causes = 3'h0;
            step(2);
            chk_bit(entity_present, 1'b0, "removed");
        end
        causes = 3'h4;
        step(3);
        acc(1'b0, VUPM_ATTR_PORT_ID, 8'h00);
        chk_val(rd, exp_id(slot_num, port_num), "id");
        acc(1'b0, VUPM_ATTR_POWER, 8'h00);
        chk_val(rd, 16'h0000, "power reset");
        acc(1'b1, VUPM_ATTR_POWER, VUPM_VAL_ON);
        step(2);
        chk_bit(coax_power_on, 1'b1, "power on");
        acc(1'b0, VUPM_ATTR_OPER, 8'h00);
        chk_val(rd, {8'h00, VUPM_OPER_ENABLED}, "oper");
        base = n_notice;
        port_fault = 1'b1;
        step(3);
        chk_val(16'(n_notice - base), 16'h1, "notice count");
        chk_val({12'h0, last_notice}, {12'h0, VUPM_NOTICE_OPER}, "notice");
        acc(1'b0, VUPM_ATTR_OPER, 8'h00);
        chk_val(rd, {8'h00, VUPM_OPER_DISABLED}, "oper");
        port_fault = 1'b0;
        step(3);
        for (k = 0; k < 3; k++) begin
            base = n_alarm;
            conds = 3'h1 << k;
            step(3);
            chk_val(16'(n_alarm - base), 16'h1, "alarm count");
            chk_val({8'h0, last_alarm}, 16'(k), "alarm code");
            chk_bit(alarm_active[k], 1'b1, "alarm level");
            conds = 3'h0;
            step(2);
        end
        acc(1'b1, VUPM_ATTR_ADMIN, VUPM_VAL_LOCKED);
        acc(1'b0, VUPM_ATTR_ADMIN, 8'h00);
        chk_val(rd, {8'h00, VUPM_VAL_LOCKED}, "lock read");
        chk_bit(user_enable, 1'b0, "locked user");
        chk_bit(coax_power_on, 1'b0, "locked power");
        base = n_alarm + n_notice;
        port_fault = 1'b1;
        conds = 3'h1;
        step(4);
        chk_val(16'(n_alarm + n_notice - base), 16'h0, "locked silent");
        chk_val({13'h0, alarm_active}, 16'h0000, "locked level");
        port_fault = 1'b0;
        conds = 3'h0;
        step(3);
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            r = (k == 0) ? 8'h02 : seed[7:0];
            acc(1'b1, VUPM_ATTR_ADMIN, r);
            acc(1'b0, VUPM_ATTR_ADMIN, 8'h00);
            chk_val(rd, {8'h00, r}, "lock rw");
            chk_bit(user_enable, r != VUPM_VAL_LOCKED, "user enable");
        end
        acc(1'b1, VUPM_ATTR_ADMIN, 8'h00);
        step(3);
        // two units of interval plus the expiry unit: thirty cycles at ten per unit
        acc(1'b1, VUPM_ATTR_INTERVAL, 8'h02);
        acc(1'b0, VUPM_ATTR_INTERVAL, 8'h00);
        chk_val(rd, 16'h0002, "interval rw");
        acc(1'b1, VUPM_ATTR_INHIBIT, 8'h01);
        base = n_alarm;
        conds = 3'h1;
        step(3);
        chk_val(16'(n_alarm - base), 16'h0, "inhibited");
        conds = 3'h0;
        base = n_notice;
        k = 0;
        while (n_notice == base && k < 40) begin
            step(1);
            k++;
        end
        chk_val({12'h0, last_notice}, {12'h0, VUPM_NOTICE_TIMER}, "timer notice");
        chk_bit(k >= 25 && k < 40, 1'b1, "timer length");
        acc(1'b0, VUPM_ATTR_INHIBIT, 8'h00);
        chk_val(rd, 16'h0000, "inhibit cleared");
        acc(1'b1, VUPM_ATTR_PORT_ID, 8'h55);
        chk_bit(er, 1'b1, "set id");
        acc(1'b1, VUPM_ATTR_OPER, 8'h01);
        chk_bit(er, 1'b1, "set oper");
        acc(1'b0, 3'h7, 8'h00);
        chk_bit(er, 1'b1, "bad attr");
        for (k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            r = seed[0] ? VUPM_VAL_ON : seed[15:8];
            acc(1'b1, VUPM_ATTR_POWER, r);
            acc(1'b0, VUPM_ATTR_POWER, 8'h00);
            chk_val(rd, {8'h00, r}, "power rw");
            chk_bit(coax_power_on, r == VUPM_VAL_ON, "power level");
        end
        // mid-run reset: the feed must fall back to off
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        chk_bit(coax_power_on, 1'b0, "power after reset");
        acc(1'b0, VUPM_ATTR_POWER, 8'h00);
        chk_val(rd, 16'h0000, "power reset value");
        stop_test();
    end
endmodule

// [verification/vupm_mgr_model.sv]
// Purpose: line terminal management party issuing get and set requests
// Assumes: requests are one-cycle pulses, answered one cycle later
// Notes:   released select and data lines show the inverse of the last value
`timescale 1ns/10ps
module vupm_mgr_model
    import vupm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        get_ack,
    input  wire logic        set_ack,
    input  wire logic        attr_error,
    input  wire logic [15:0] get_data,
    output logic             get_req,
    output logic             set_req,
    output logic [2:0]       attr_sel,
    output logic [7:0]       set_data
);
    initial begin
        get_req  = 1'b0;
        set_req  = 1'b0;
        attr_sel = 3'h0;
        set_data = 8'h00;
    end

    // only get and set are offered; gap lets the caller issue the request promptly or slowly
    task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] din,
                          input int gap, output logic [15:0] dout, output logic err,
                          output logic ok);
        int n;
        n = 0;
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        get_req  = !wr;
        set_req  = wr;
        attr_sel = sel;
        set_data = din;
        @(posedge clk_sys);
        #1;
        get_req  = 1'b0;
        set_req  = 1'b0;
        attr_sel = ~sel;
        set_data = ~din;
        while ((get_ack | set_ack) !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        ok   = (n < 4);
        dout = get_data;
        err  = attr_error;
    endtask
endmodule

// [verilog/vupm_attr_bank.sv]
// Purpose: management attribute bank of one RF video user-side port
// Assumes: get/set strobes come from the management channel logic
// Notes:   alarms are raised as pulse plus code; each code also has a level output
// Notes on behaviour
// [R1] port identifier is slot byte high, port byte low, sixteen bits
// [R2] lock attribute is one read/write byte; 1 locks, 0 unlocks
// [R3] locked port blocks user functions and silences alarms and change notices
// [R4] operating condition reads 0 when capable, 1 when not
// [R5] power feed byte 1 enables coax power; 0 after reset disables it
// [R6] operating condition change emits change notice 2 unless locked
// [R7] alarm 0 raised when no video signal is present
// [R8] alarm 1 raised when rf output is below rated level
// [R9] alarm 2 raised when rf output is above rated level
// [R10] entity exists when built in, provisioned, or plug-and-play fitted
// [R11] entity removed once slot neither provisioned nor fitted
// [R12] manager uses only get and set, no create or delete
// [R13] inhibit withholds alarm pulses, not alarm_active, for interval; expiry emits change notice 3; here it lasts interval plus one unit
`timescale 1ns/10ps
module vupm_attr_bank
    import vupm_pkg::*;
#(
    parameter longint UNIT_CYCLES = VUPM_UNIT_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [7:0] slot_num,
    input  wire logic [7:0] port_num,
    input  wire logic       factory_port,
    input  wire logic       slot_provisioned,
    input  wire logic       slot_fitted,
    input  wire logic       port_fault,
    input  wire logic       video_signal_absent,
    input  wire logic       rf_level_under_range,
    input  wire logic       rf_level_over_range,
    input  wire logic       get_req,
    input  wire logic       set_req,
    input  wire logic [2:0] attr_sel,
    input  wire logic [7:0] set_data,
    output logic [15:0]     get_data,
    output logic            get_ack,
    output logic            set_ack,
    output logic            attr_error,
    output logic            entity_present,
    output logic            user_enable,
    output logic            coax_power_on,
    output logic            alarm_pulse,
    output logic [7:0]      alarm_code,
    output logic [2:0]      alarm_active,
    output logic            attribute_change_notice,
    output logic [3:0]      notice_number
);
    typedef struct packed {
        logic [15:0] get_data;
        logic        get_ack;
        logic        set_ack;
        logic        attr_error;
        logic        present;
        logic [7:0]  admin_lock;
        logic [7:0]  operating_condition;
        logic [7:0]  alarm_report_inhibit;
        logic [7:0]  alarm_inhibit_interval;
        logic [7:0]  remaining;
        logic [7:0]  coax_power_feed;
        logic [2:0]  alarm_seen;
        logic [2:0]  alarm_active;
        logic        alarm_pulse;
        logic [7:0]  alarm_code;
        logic        notice;
        logic [3:0]  notice_number;
        logic        user_enable;
        logic        power_on;
    } vupm_st_t;

    vupm_st_t st_reg;
    vupm_st_t st_next;
    logic     unit_tick;
    logic     locked;
    logic     inhibit_on;
    logic [2:0] cond_now;
    logic [7:0] oper_now;

    function automatic logic attr_valid(input logic [2:0] a);
        attr_valid = (a >= VUPM_ATTR_PORT_ID) && (a <= VUPM_ATTR_POWER);
    endfunction

    function automatic logic attr_writable(input logic [2:0] a);
        attr_writable = (a == VUPM_ATTR_ADMIN) || (a == VUPM_ATTR_INHIBIT) ||
                        (a == VUPM_ATTR_INTERVAL) || (a == VUPM_ATTR_POWER);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    vupm_tick #(
        .PERIOD (UNIT_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (inhibit_on),
        .tick    (unit_tick)
    );

    assign locked     = (st_reg.admin_lock == VUPM_VAL_LOCKED);
    assign inhibit_on = st_reg.present && (st_reg.alarm_report_inhibit != 8'h00);
    assign cond_now   = {rf_level_over_range, rf_level_under_range, video_signal_absent};
    assign oper_now   = (port_fault || !st_reg.present) ? VUPM_OPER_DISABLED
                                                        : VUPM_OPER_ENABLED; // [R4]

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       emit;
        logic [2:0] rising;
        logic       inhibit_wr;
        emit                  = 1'b0;
        rising                = 3'h0;
        inhibit_wr            = 1'b0;
        st_next               = st_reg;
        st_next.get_ack       = 1'b0;
        st_next.set_ack       = 1'b0;
        st_next.attr_error    = 1'b0;
        st_next.alarm_pulse   = 1'b0;
        st_next.notice        = 1'b0;

        st_next.present = factory_port || slot_provisioned || slot_fitted; // [R10] [R11]

        // get and set only; an absent entity answers with an error
        if (get_req) begin // [R12]
            st_next.get_ack    = 1'b1;
            st_next.attr_error = !attr_valid(attr_sel) || !st_reg.present;
            case (attr_sel)
                VUPM_ATTR_PORT_ID:  st_next.get_data = {slot_num, port_num}; // [R1]
                VUPM_ATTR_ADMIN:    st_next.get_data = {8'h00, st_reg.admin_lock};
                VUPM_ATTR_OPER:     st_next.get_data = {8'h00, st_reg.operating_condition};
                VUPM_ATTR_INHIBIT:  st_next.get_data = {8'h00, st_reg.alarm_report_inhibit};
                VUPM_ATTR_INTERVAL: st_next.get_data = {8'h00, st_reg.alarm_inhibit_interval};
                VUPM_ATTR_POWER:    st_next.get_data = {8'h00, st_reg.coax_power_feed};
                default:            st_next.get_data = 16'h0000;
            endcase
        end else if (set_req) begin
            st_next.set_ack    = 1'b1;
            st_next.attr_error = !attr_writable(attr_sel) || !st_reg.present;
            if (attr_writable(attr_sel) && st_reg.present) begin
                case (attr_sel)
                    VUPM_ATTR_ADMIN:    st_next.admin_lock = set_data; // [R2]
                    VUPM_ATTR_INHIBIT: begin
                        inhibit_wr                   = 1'b1;
                        st_next.alarm_report_inhibit = set_data;
                        st_next.remaining            = st_reg.alarm_inhibit_interval;
                    end
                    VUPM_ATTR_INTERVAL: st_next.alarm_inhibit_interval = set_data;
                    VUPM_ATTR_POWER:    st_next.coax_power_feed = set_data; // [R5]
                    default:            st_next.attr_error = 1'b1;
                endcase
            end
        end

        // inhibit interval countdown; expiry clears the inhibit
        // a fresh inhibit write restarts the countdown, so it wins over expiry
        if (inhibit_on && unit_tick && !inhibit_wr) begin // [R13]
            if (st_reg.remaining == 8'h00) begin
                st_next.alarm_report_inhibit = 8'h00;
                emit = !locked;
                st_next.notice_number = VUPM_NOTICE_TIMER;
            end else begin
                st_next.remaining = st_reg.remaining - 8'h01;
            end
        end

        // operating condition change wins the notice slot over the timer
        st_next.operating_condition = oper_now;
        if (oper_now != st_reg.operating_condition && !locked) begin // [R6] [R3]
            emit = 1'b1;
            st_next.notice_number = VUPM_NOTICE_OPER;
        end
        st_next.notice = emit;

        // alarms: one code per cycle, lowest number first, rest caught next cycle
        st_next.alarm_active = locked ? 3'h0 : (cond_now & {3{st_reg.present}}); // [R3]
        rising = cond_now & ~st_reg.alarm_seen & {3{st_reg.present}};
        if (!locked && !inhibit_on) begin // [R3] [R13]
            if (rising[0]) begin // [R7]
                st_next.alarm_pulse   = 1'b1;
                st_next.alarm_code    = VUPM_ALARM_LOS;
                st_next.alarm_seen[0] = 1'b1;
            end else if (rising[1]) begin // [R8]
                st_next.alarm_pulse   = 1'b1;
                st_next.alarm_code    = VUPM_ALARM_LOW;
                st_next.alarm_seen[1] = 1'b1;
            end else if (rising[2]) begin // [R9]
                st_next.alarm_pulse   = 1'b1;
                st_next.alarm_code    = VUPM_ALARM_HIGH;
                st_next.alarm_seen[2] = 1'b1;
            end
        end
        st_next.alarm_seen = st_next.alarm_seen & cond_now;

        st_next.user_enable = st_reg.present && !locked; // [R3]
        st_next.power_on    = st_reg.present && !locked &&
                              (st_reg.coax_power_feed == VUPM_VAL_ON); // [R5]

        // removal returns attributes to their defaults
        if (!st_next.present) begin // [R11]
            st_next.admin_lock             = VUPM_ADMIN_RST;
            st_next.alarm_report_inhibit   = VUPM_INHIBIT_RST;
            st_next.alarm_inhibit_interval = VUPM_INTERVAL_RST;
            st_next.coax_power_feed        = VUPM_POWER_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg                     <= '0;
            st_reg.admin_lock          <= VUPM_ADMIN_RST;
            st_reg.coax_power_feed     <= VUPM_POWER_RST;
            st_reg.operating_condition <= VUPM_OPER_DISABLED;
        end else begin
            st_reg <= st_next;
        end
    end

    assign get_data                = st_reg.get_data;
    assign get_ack                 = st_reg.get_ack;
    assign set_ack                 = st_reg.set_ack;
    assign attr_error              = st_reg.attr_error;
    assign entity_present          = st_reg.present;
    assign user_enable             = st_reg.user_enable;
    assign coax_power_on           = st_reg.power_on;
    assign alarm_pulse             = st_reg.alarm_pulse;
    assign alarm_code              = st_reg.alarm_code;
    assign alarm_active            = st_reg.alarm_active;
    assign attribute_change_notice = st_reg.notice;
    assign notice_number           = st_reg.notice_number;

    ////////////////////////////////////////////////////////////////////////////
    a_get_port_id: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
        get_req && !set_req && attr_sel == VUPM_ATTR_PORT_ID |=>
        get_ack && get_data == {$past(slot_num), $past(port_num)})
        else $error("port identifier mismatch");

    a_lock_stored: assert property (@(posedge clk_sys) disable iff (srst) // [R2]
        set_req && !get_req && attr_sel == VUPM_ATTR_ADMIN && entity_present |=>
        st_reg.admin_lock == $past(set_data) || !entity_present)
        else $error("lock write not stored");

    a_lock_silences: assert property (@(posedge clk_sys) disable iff (srst) // [R3]
        locked |=> !alarm_pulse || !$past(locked))
        else $error("alarm while locked");

    a_lock_users: assert property (@(posedge clk_sys) disable iff (srst) // [R3]
        $past(locked) |-> !user_enable && !coax_power_on)
        else $error("user function while locked");

    a_oper_value: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
        get_req && !set_req && attr_sel == VUPM_ATTR_OPER |=>
        get_data == {8'h00, (($past(port_fault, 2) || !$past(entity_present, 2)) ?
        VUPM_OPER_DISABLED : VUPM_OPER_ENABLED)})
        else $error("operating condition wrong");

    a_oper_notice: assert property (@(posedge clk_sys) disable iff (srst) // [R6]
        oper_now != st_reg.operating_condition && !locked |=>
        attribute_change_notice && notice_number == VUPM_NOTICE_OPER)
        else $error("missing change notice 2");

    a_los_alarm: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
        !locked && !inhibit_on && video_signal_absent && !st_reg.alarm_seen[0] &&
        st_reg.present |=> alarm_pulse && alarm_code == VUPM_ALARM_LOS)
        else $error("missing signal alarm");

    a_power_reset: assert property (@(posedge clk_sys) // [R5]
        srst |=> st_reg.coax_power_feed == VUPM_POWER_RST && !coax_power_on)
        else $error("power feed not off after reset");

    a_inhibit_quiet: assert property (@(posedge clk_sys) disable iff (srst) // [R13]
        inhibit_on |=> !alarm_pulse)
        else $error("alarm during inhibit");

    a_presence: assert property (@(posedge clk_sys) disable iff (srst) // [R10]
        (factory_port || slot_provisioned || slot_fitted) |=> entity_present)
        else $error("entity not created");
endmodule

// [verilog/vupm_tick.sv]
// Purpose: enable pulse divider for the inhibit interval
// Assumes: period at least 1
// Notes:   pulse is one clk_sys cycle wide
`timescale 1ns/10ps
module vupm_tick
    import vupm_pkg::*;
#(
    parameter longint PERIOD = VUPM_UNIT_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic run,
    output logic      tick
);
    typedef struct packed {
        logic [39:0] cnt;
        logic        tick;
    } vupm_tick_st_t;

    vupm_tick_st_t st_reg;
    vupm_tick_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!run) begin
            st_next.cnt = 40'h0;
        end else if (st_reg.cnt == 40'(PERIOD - 1)) begin
            st_next.cnt  = 40'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 40'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule
